// file: include/ttc_pkg.sv
// package: register map, field positions and reset values of the triple timer/counter
package ttc_pkg;
  localparam logic [7:0] CTRL01_ADDR = 8'h88;
  localparam logic [7:0] MODE01_ADDR = 8'h89;
  localparam logic [7:0] CNT0L_ADDR  = 8'h8A;
  localparam logic [7:0] CNT1L_ADDR  = 8'h8B;
  localparam logic [7:0] CNT0H_ADDR  = 8'h8C;
  localparam logic [7:0] CNT1H_ADDR  = 8'h8D;
  localparam logic [7:0] PRESC_ADDR  = 8'h8E;
  localparam logic [7:0] CTRL2_ADDR  = 8'hC8;
  localparam logic [7:0] RCL_ADDR    = 8'hCA;
  localparam logic [7:0] RCH_ADDR    = 8'hCB;
  localparam logic [7:0] CNT2L_ADDR  = 8'hCC;
  localparam logic [7:0] CNT2H_ADDR  = 8'hCD;
  localparam logic [7:0] PRESC_RST   = 8'h01;
  localparam logic [7:0] ZERO_RST    = 8'h00;
  // control flag positions
  localparam int OVF1_BIT = 7;
  localparam int RUN1_BIT = 6;
  localparam int OVF0_BIT = 5;
  localparam int RUN0_BIT = 4;
  // mode select: timer n nibble at 4*n; gate 3, source 2, mode 1..0
  localparam int GATE_BIT = 3;
  localparam int CT_BIT   = 2;
  // prescale control: timer n fast bit at FAST_BASE+n
  localparam int FAST_BASE = 3;
  // timer 2 control
  localparam int OVF2_BIT  = 7;
  localparam int TRGF_BIT  = 6;
  localparam int RXB_BIT   = 5;
  localparam int TXB_BIT   = 4;
  localparam int EXEN_BIT  = 3;
  localparam int RUN2_BIT  = 2;
  localparam int CT2_BIT   = 1;
  localparam int CPRL_BIT  = 0;
  // prescale division counts and timer 0/1 mode codes
  localparam logic [3:0] DIV_SLOW = 4'hB;
  localparam logic [3:0] DIV_FAST = 4'h3;
  localparam logic [3:0] DIV_BAUD = 4'h1;
  localparam logic [1:0] MODE13 = 2'h0;
  localparam logic [1:0] MODE16 = 2'h1;
  localparam logic [1:0] MODE8R = 2'h2;
  localparam logic [1:0] MODESP = 2'h3;
endpackage

// file: logic/ttc_timers.sv
// triple timer/counter with register port
`timescale 1ns/1ps
module ttc_timers (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       timer0_event_pin_i,
  input  wire logic       timer1_event_pin_i,
  input  wire logic       timer2_event_pin_i,
  input  wire logic       ext_irq0_pin_n_i,
  input  wire logic       ext_irq1_pin_n_i,
  input  wire logic       timer2_trigger_input_i,
  output logic            timer0_overflow_pulse_o,
  output logic            timer1_overflow_pulse_o,
  output logic            timer2_overflow_pulse_o,
  output logic            baud_shift_clk_o,
  output logic            timer2_irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [5:0] pin_raw, sync1_q, sync2_q, prev_q, fall;
  assign pin_raw = {ext_irq1_pin_n_i, ext_irq0_pin_n_i, timer2_trigger_input_i,
                    timer2_event_pin_i, timer1_event_pin_i, timer0_event_pin_i};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 6'h3F;
      sync2_q <= 6'h3F;
      prev_q  <= 6'h3F;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  assign fall = prev_q & ~sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] cf_q, cf_d, ms_q, ms_d, ck_q, ck_d, t2c_q, t2c_d;
  logic [7:0] c0l_q, c0l_d, c0h_q, c0h_d, c1l_q, c1l_d, c1h_q, c1h_d;
  logic [7:0] rcl_q, rcl_d, rch_q, rch_d;
  logic [15:0] t2_q, t2_d;
  logic [3:0] pre_q [3];
  logic [3:0] pre_d [3];
  logic [2:0] tick;
  logic       p0_q, p1_q, p2_q, bclk_q, irq_q;
  logic       p0_d, p1_d, p2_d, bclk_d;
  logic [7:0] rdata_q, rdata_d;

  function automatic logic wr(input logic [7:0] a);
    wr = reg_wr_i && (reg_addr_i == a);
  endfunction

  wire baud = t2c_q[ttc_pkg::RXB_BIT] | t2c_q[ttc_pkg::TXB_BIT];

  // prescalers: divide by 12 or 4, timer 2 by 2 in baud mode
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pre
      logic [3:0] lim;
      always_comb begin
        if (g == 2 && baud)
          lim = ttc_pkg::DIV_BAUD;
        else if (ck_q[ttc_pkg::FAST_BASE + g])
          lim = ttc_pkg::DIV_FAST;
        else
          lim = ttc_pkg::DIV_SLOW;
        pre_d[g] = (pre_q[g] >= lim) ? 4'h0 : pre_q[g] + 4'h1;
        tick[g]  = (pre_q[g] >= lim);
      end
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
          pre_q[g] <= 4'h0;
        else
          pre_q[g] <= pre_d[g];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // count enables
  wire [1:0] m0 = ms_q[1:0];
  wire [1:0] m1 = ms_q[5:4];
  wire src0 = ms_q[ttc_pkg::CT_BIT] ? fall[0] : tick[0];
  wire src1 = ms_q[4 + ttc_pkg::CT_BIT] ? fall[1] : tick[1];
  wire src2 = t2c_q[ttc_pkg::CT2_BIT] ? fall[2] : tick[2];
  wire run0 = cf_q[ttc_pkg::RUN0_BIT] &
              (~ms_q[ttc_pkg::GATE_BIT] | sync2_q[4]);
  // timer 0 mode 3 steals timer 1 run; timer 1 then runs unless itself mode 3 or held by its gate
  wire t0split = (m0 == ttc_pkg::MODESP);
  wire run1 = (t0split ? 1'b1 : cf_q[ttc_pkg::RUN1_BIT]) &
              (~ms_q[4 + ttc_pkg::GATE_BIT] | sync2_q[5]) &
              (m1 != ttc_pkg::MODESP);
  wire inc0 = run0 & src0;
  wire inc0h = t0split & cf_q[ttc_pkg::RUN1_BIT] & tick[0];
  wire inc1 = run1 & src1;
  wire inc2 = t2c_q[ttc_pkg::RUN2_BIT] & src2;

  ////////////////////////////////////////////////////////////////////////////
  // timer 0/1 counting
  logic ov0, ov0h, ov1;
  always_comb begin
    c0l_d = c0l_q;
    c0h_d = c0h_q;
    ov0   = 1'b0;
    ov0h  = 1'b0;
    if (inc0) begin
      unique case (m0)
        ttc_pkg::MODE13: begin
          ov0 = (c0l_q[4:0] == 5'h1F) && (c0h_q == 8'hFF);
          c0l_d = {c0l_q[7:5], c0l_q[4:0] + 5'h01};
          if (c0l_q[4:0] == 5'h1F)
            c0h_d = c0h_q + 8'h01;
        end
        ttc_pkg::MODE16: begin
          ov0 = ({c0h_q, c0l_q} == 16'hFFFF);
          {c0h_d, c0l_d} = {c0h_q, c0l_q} + 16'h0001;
        end
        ttc_pkg::MODE8R: begin
          ov0 = (c0l_q == 8'hFF);
          c0l_d = ov0 ? c0h_q : c0l_q + 8'h01;
        end
        ttc_pkg::MODESP: begin
          ov0 = (c0l_q == 8'hFF);
          c0l_d = c0l_q + 8'h01;
        end
      endcase
    end
    if (inc0h) begin
      ov0h  = (c0h_q == 8'hFF);
      c0h_d = c0h_q + 8'h01;
    end
    if (wr(ttc_pkg::CNT0L_ADDR))
      c0l_d = reg_wdata_i;
    if (wr(ttc_pkg::CNT0H_ADDR))
      c0h_d = reg_wdata_i;
  end

  always_comb begin
    c1l_d = c1l_q;
    c1h_d = c1h_q;
    ov1   = 1'b0;
    if (inc1) begin
      unique case (m1)
        ttc_pkg::MODE13: begin
          ov1 = (c1l_q[4:0] == 5'h1F) && (c1h_q == 8'hFF);
          c1l_d = {c1l_q[7:5], c1l_q[4:0] + 5'h01};
          if (c1l_q[4:0] == 5'h1F)
            c1h_d = c1h_q + 8'h01;
        end
        ttc_pkg::MODE16: begin
          ov1 = ({c1h_q, c1l_q} == 16'hFFFF);
          {c1h_d, c1l_d} = {c1h_q, c1l_q} + 16'h0001;
        end
        ttc_pkg::MODE8R: begin
          ov1 = (c1l_q == 8'hFF);
          c1l_d = ov1 ? c1h_q : c1l_q + 8'h01;
        end
        ttc_pkg::MODESP: ;
      endcase
    end
    if (wr(ttc_pkg::CNT1L_ADDR))
      c1l_d = reg_wdata_i;
    if (wr(ttc_pkg::CNT1H_ADDR))
      c1h_d = reg_wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer 2
  logic ov2, trig;
  always_comb begin
    t2_d  = t2_q;
    rcl_d = rcl_q;
    rch_d = rch_q;
    ov2   = 1'b0;
    trig  = fall[3] & t2c_q[ttc_pkg::EXEN_BIT];
    if (inc2) begin
      ov2  = (t2_q == 16'hFFFF);
      t2_d = t2_q + 16'h0001;
      if (ov2 && (baud || !t2c_q[ttc_pkg::CPRL_BIT]))
        t2_d = {rch_q, rcl_q};
    end
    if (trig && !baud) begin
      if (t2c_q[ttc_pkg::CPRL_BIT])
        {rch_d, rcl_d} = t2_q;
      else
        t2_d = {rch_q, rcl_q};
    end
    if (wr(ttc_pkg::RCL_ADDR))
      rcl_d = reg_wdata_i;
    if (wr(ttc_pkg::RCH_ADDR))
      rch_d = reg_wdata_i;
    if (wr(ttc_pkg::CNT2L_ADDR))
      t2_d[7:0] = reg_wdata_i;
    if (wr(ttc_pkg::CNT2H_ADDR))
      t2_d[15:8] = reg_wdata_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers; hardware set beats software clear
  always_comb begin
    cf_d   = wr(ttc_pkg::CTRL01_ADDR) ? reg_wdata_i : cf_q;
    ms_d   = wr(ttc_pkg::MODE01_ADDR) ? reg_wdata_i : ms_q;
    ck_d   = wr(ttc_pkg::PRESC_ADDR) ? reg_wdata_i : ck_q;
    t2c_d  = wr(ttc_pkg::CTRL2_ADDR) ? reg_wdata_i : t2c_q;
    if (ov0)
      cf_d[ttc_pkg::OVF0_BIT] = 1'b1;
    if (ov1 || ov0h)
      cf_d[ttc_pkg::OVF1_BIT] = 1'b1;
    if (ov2 && !baud)
      t2c_d[ttc_pkg::OVF2_BIT] = 1'b1;
    if (trig)
      t2c_d[ttc_pkg::TRGF_BIT] = 1'b1;
    p0_d   = ov0;
    p1_d   = ov1 | ov0h;
    p2_d   = ov2 & ~baud;
    bclk_d = ov2 & baud;
    unique case (reg_addr_i)
      ttc_pkg::CTRL01_ADDR: rdata_d = cf_q;
      ttc_pkg::MODE01_ADDR: rdata_d = ms_q;
      ttc_pkg::CNT0L_ADDR:  rdata_d = c0l_q;
      ttc_pkg::CNT1L_ADDR:  rdata_d = c1l_q;
      ttc_pkg::CNT0H_ADDR:  rdata_d = c0h_q;
      ttc_pkg::CNT1H_ADDR:  rdata_d = c1h_q;
      ttc_pkg::PRESC_ADDR:  rdata_d = ck_q;
      ttc_pkg::CTRL2_ADDR:  rdata_d = t2c_q;
      ttc_pkg::RCL_ADDR:    rdata_d = rcl_q;
      ttc_pkg::RCH_ADDR:    rdata_d = rch_q;
      ttc_pkg::CNT2L_ADDR:  rdata_d = t2_q[7:0];
      ttc_pkg::CNT2H_ADDR:  rdata_d = t2_q[15:8];
      default:             rdata_d = 8'h00;
    endcase
    if (!reg_rd_i)
      rdata_d = rdata_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cf_q    <= ttc_pkg::ZERO_RST;
      ms_q    <= ttc_pkg::ZERO_RST;
      ck_q    <= ttc_pkg::PRESC_RST;
      t2c_q   <= ttc_pkg::ZERO_RST;
      c0l_q   <= ttc_pkg::ZERO_RST;
      c0h_q   <= ttc_pkg::ZERO_RST;
      c1l_q   <= ttc_pkg::ZERO_RST;
      c1h_q   <= ttc_pkg::ZERO_RST;
      rcl_q   <= ttc_pkg::ZERO_RST;
      rch_q   <= ttc_pkg::ZERO_RST;
      t2_q    <= 16'h0000;
      p0_q    <= 1'b0;
      p1_q    <= 1'b0;
      p2_q    <= 1'b0;
      bclk_q  <= 1'b0;
      irq_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      cf_q    <= cf_d;
      ms_q    <= ms_d;
      ck_q    <= ck_d;
      t2c_q   <= t2c_d;
      c0l_q   <= c0l_d;
      c0h_q   <= c0h_d;
      c1l_q   <= c1l_d;
      c1h_q   <= c1h_d;
      rcl_q   <= rcl_d;
      rch_q   <= rch_d;
      t2_q    <= t2_d;
      p0_q    <= p0_d;
      p1_q    <= p1_d;
      p2_q    <= p2_d;
      bclk_q  <= bclk_d;
      irq_q   <= t2c_d[ttc_pkg::OVF2_BIT] | t2c_d[ttc_pkg::TRGF_BIT];
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o             = rdata_q;
  assign timer0_overflow_pulse_o = p0_q;
  assign timer1_overflow_pulse_o = p1_q;
  assign timer2_overflow_pulse_o = p2_q;
  assign baud_shift_clk_o        = bclk_q;
  assign timer2_irq_o            = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_ck_reset;
    @(posedge clk_i) $rose(rst_n_i) |-> ck_q == ttc_pkg::PRESC_RST;
  endproperty
  a_ck_reset: assert property (p_ck_reset) else $error("prescale reset wrong");

  property p_pulse0;
    @(posedge clk_i) disable iff (!rst_n_i) ov0 |=> p0_q ##1 !p0_q;
  endproperty
  a_pulse0: assert property (p_pulse0) else $error("timer0 pulse not one clock");

  property p_tf0;
    @(posedge clk_i) disable iff (!rst_n_i) ov0 |=> cf_q[ttc_pkg::OVF0_BIT];
  endproperty
  a_tf0: assert property (p_tf0) else $error("timer0 flag not set");

  property p_reload8;
    @(posedge clk_i) disable iff (!rst_n_i)
      inc0 && m0 == ttc_pkg::MODE8R && c0l_q == 8'hFF && !reg_wr_i |=> c0l_q == $past(c0h_q);
  endproperty
  a_reload8: assert property (p_reload8) else $error("mode 2 reload missed");

  property p_hold1;
    @(posedge clk_i) disable iff (!rst_n_i)
      m1 == ttc_pkg::MODESP && !reg_wr_i |=> $stable(c1l_q) && $stable(c1h_q);
  endproperty
  a_hold1: assert property (p_hold1) else $error("timer1 mode 3 not holding");

  property p_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
      ms_q[ttc_pkg::GATE_BIT] && !sync2_q[4] |-> !inc0;
  endproperty
  a_gate: assert property (p_gate) else $error("gate ignored");

  property p_capture;
    @(posedge clk_i) disable iff (!rst_n_i)
      trig && !baud && t2c_q[ttc_pkg::CPRL_BIT] && !reg_wr_i |=> {rch_q, rcl_q} == $past(t2_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture failed");

  property p_baud_noflag;
    @(posedge clk_i) disable iff (!rst_n_i)
      ov2 && baud |=> bclk_q && !p2_q;
  endproperty
  a_baud_noflag: assert property (p_baud_noflag) else $error("baud overflow wrong");

  property p_slow_div;
    @(posedge clk_i) disable iff (!rst_n_i)
      // only judged while the slow setting stays put; a switch to fast ends the count at 3 instead of 11
      tick[0] && !ck_q[ttc_pkg::FAST_BASE] ##1 !ck_q[ttc_pkg::FAST_BASE] [*8] |-> !tick[0];
  endproperty
  a_slow_div: assert property (p_slow_div) else $error("divide by 12 broken");

  c_ov0: cover property (@(posedge clk_i) disable iff (!rst_n_i) ov0);
  c_ov0h: cover property (@(posedge clk_i) disable iff (!rst_n_i) ov0h);
  c_baud: cover property (@(posedge clk_i) disable iff (!rst_n_i) ov2 && baud);
  c_cap: cover property (@(posedge clk_i) disable iff (!rst_n_i) trig);
endmodule  // ttc_timers

// file: sim/tb.sv
// self-checking bench for the triple timer/counter, driven through its register port
`timescale 1ns/1ps
module tb;
  logic       clk;
  logic       rst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [2:0] ev;
  logic [1:0] irq_n;
  logic       trig;
  logic [3:0] pulse;
  logic       t2_irq;
  logic [7:0] v;
  int         n_fail;
  int         tests_run;
  int         cyc;
  int         n;

  ttc_timers dut (
    .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .timer0_event_pin_i(ev[0]), .timer1_event_pin_i(ev[1]), .timer2_event_pin_i(ev[2]),
    .ext_irq0_pin_n_i(irq_n[0]), .ext_irq1_pin_n_i(irq_n[1]),
    .timer2_trigger_input_i(trig),
    .timer0_overflow_pulse_o(pulse[0]), .timer1_overflow_pulse_o(pulse[1]),
    .timer2_overflow_pulse_o(pulse[2]), .baud_shift_clk_o(pulse[3]),
    .timer2_irq_o(t2_irq)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // strobe dropped on the next falling edge; a following call waits one more edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // sampled one and a half cycles after the read edge, data holds until the next read
  task automatic rd_val(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_val(a, d);
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask

  // pins are slow async inputs: hold each level long enough for the synchroniser
  task automatic fall(input int k);
    @(negedge clk);
    if (k == 3) trig = 1'b0;
    else ev[k] = 1'b0;
    repeat (4) @(negedge clk);
    if (k == 3) trig = 1'b1;
    else ev[k] = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic wait_pulse(input int k, input int lim);
    n = 0;
    @(negedge clk);
    while (pulse[k] !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // a pulse wider than one clock shows up as a period of 1
  task automatic period(input int k, input logic [15:0] e, input string nm);
    wait_pulse(k, 100);
    wait_pulse(k, 100);
    chk(nm, e, 16'(n + 1));
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    ev = 3'h7;
    irq_n = 2'h3;
    trig = 1'b1;
    n_fail = 0;
    tests_run = 0;
    cyc = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    rd_chk("prescale_rst", ttc_pkg::PRESC_ADDR, 8'h01);
    rd_chk("t01ctl_rst", ttc_pkg::CTRL01_ADDR, 8'h00);
    rd_chk("t2ctl_rst", ttc_pkg::CTRL2_ADDR, 8'h00);
    wr_reg(8'h90, 8'hAA);
    rd_chk("unmapped", 8'h90, 8'h00);
    // timer 0 mode 2, two ticks per reload, fast then slow prescale
    wr_reg(ttc_pkg::CNT0H_ADDR, 8'hFE);
    wr_reg(ttc_pkg::CNT0L_ADDR, 8'hFE);
    wr_reg(ttc_pkg::MODE01_ADDR, 8'h02);
    wr_reg(ttc_pkg::PRESC_ADDR, 8'h09);
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h10);
    period(0, 16'd8, "fast_period");
    wr_reg(ttc_pkg::PRESC_ADDR, 8'h01);
    period(0, 16'd24, "slow_period");
    rd_chk("tf0", ttc_pkg::CTRL01_ADDR, 8'h30);
    // gate held closed by the asserted irq pin
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h00);
    wr_reg(ttc_pkg::MODE01_ADDR, 8'h0A);
    irq_n[0] = 1'b0;
    wr_reg(ttc_pkg::CNT0L_ADDR, 8'hFF);
    wr_reg(ttc_pkg::PRESC_ADDR, 8'h09);
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h10);
    wait_pulse(0, 40);
    chk("gate_closed", 16'd40, 16'(n));
    irq_n[0] = 1'b1;
    wait_pulse(0, 40);
    chk("gate_open", 16'd1, 16'(n < 20));
    // mode 0 wraps at 13 bits, mode 1 at 16
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h00);
    wr_reg(ttc_pkg::MODE01_ADDR, 8'h00);
    wr_reg(ttc_pkg::CNT0L_ADDR, 8'h1F);
    wr_reg(ttc_pkg::CNT0H_ADDR, 8'hFF);
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h10);
    wait_pulse(0, 20);
    chk("m0_wrap", 16'd1, 16'(n < 20));
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h00);
    rd_chk("m0_high", ttc_pkg::CNT0H_ADDR, 8'h00);
    wr_reg(ttc_pkg::MODE01_ADDR, 8'h01);
    wr_reg(ttc_pkg::CNT0L_ADDR, 8'h1F);
    wr_reg(ttc_pkg::CNT0H_ADDR, 8'hFF);
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h10);
    wait_pulse(0, 60);
    chk("m1_no_wrap", 16'd60, 16'(n));
    wr_reg(ttc_pkg::CNT0L_ADDR, 8'hFE);
    wait_pulse(0, 20);
    chk("m1_wrap", 16'd1, 16'(n < 20));
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h00);
    rd_chk("m1_high", ttc_pkg::CNT0H_ADDR, 8'h00);
    // timer 1 counting pin edges
    wr_reg(ttc_pkg::MODE01_ADDR, 8'h60);
    wr_reg(ttc_pkg::CNT1H_ADDR, 8'hFE);
    wr_reg(ttc_pkg::CNT1L_ADDR, 8'hFE);
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h40);
    fall(1);
    rd_chk("cnt_one", ttc_pkg::CNT1L_ADDR, 8'hFF);
    fall(1);
    rd_chk("cnt_reload", ttc_pkg::CNT1L_ADDR, 8'hFE);
    rd_chk("tf1", ttc_pkg::CTRL01_ADDR, 8'hC0);
    // split mode
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h00);
    wr_reg(ttc_pkg::MODE01_ADDR, 8'h33);
    wr_reg(ttc_pkg::CNT1L_ADDR, 8'h55);
    wr_reg(ttc_pkg::CNT0L_ADDR, 8'hFF);
    wr_reg(ttc_pkg::CNT0H_ADDR, 8'hFF);
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h40);
    repeat (40) @(negedge clk);
    rd_chk("split_tf1", ttc_pkg::CTRL01_ADDR, 8'hC0);
    rd_chk("t1_hold", ttc_pkg::CNT1L_ADDR, 8'h55);
    rd_chk("tl0_idle", ttc_pkg::CNT0L_ADDR, 8'hFF);
    wr_reg(ttc_pkg::MODE01_ADDR, 8'h13);
    repeat (40) @(negedge clk);
    rd_val(ttc_pkg::CNT1L_ADDR, v);
    chk("t1_runs", 16'd1, 16'(v !== 8'h55));
    // timer 2 plain, capture, forced and overflow reload
    wr_reg(ttc_pkg::CTRL01_ADDR, 8'h00);
    wr_reg(ttc_pkg::PRESC_ADDR, 8'h21);
    wr_reg(ttc_pkg::CNT2L_ADDR, 8'hFE);
    wr_reg(ttc_pkg::CNT2H_ADDR, 8'hFF);
    wr_reg(ttc_pkg::CTRL2_ADDR, 8'h05);
    wait_pulse(2, 30);
    chk("t2_wrap", 16'd1, 16'(n < 30));
    rd_chk("tf2", ttc_pkg::CTRL2_ADDR, 8'h85);
    chk("t2_irq", 16'd1, {15'h0000, t2_irq});
    wr_reg(ttc_pkg::CTRL2_ADDR, 8'h09);
    wr_reg(ttc_pkg::CNT2L_ADDR, 8'h34);
    wr_reg(ttc_pkg::CNT2H_ADDR, 8'h12);
    fall(3);
    rd_chk("cap_low", ttc_pkg::RCL_ADDR, 8'h34);
    rd_chk("cap_high", ttc_pkg::RCH_ADDR, 8'h12);
    rd_chk("cap_flag", ttc_pkg::CTRL2_ADDR, 8'h49);
    wr_reg(ttc_pkg::CTRL2_ADDR, 8'h08);
    wr_reg(ttc_pkg::RCL_ADDR, 8'hF0);
    wr_reg(ttc_pkg::RCH_ADDR, 8'hFF);
    wr_reg(ttc_pkg::CNT2L_ADDR, 8'h00);
    wr_reg(ttc_pkg::CNT2H_ADDR, 8'h00);
    fall(3);
    rd_chk("force_low", ttc_pkg::CNT2L_ADDR, 8'hF0);
    rd_chk("force_high", ttc_pkg::CNT2H_ADDR, 8'hFF);
    // slow prescale leaves time to read the flag and stop before the next tick
    wr_reg(ttc_pkg::PRESC_ADDR, 8'h01);
    wr_reg(ttc_pkg::CNT2L_ADDR, 8'hFE);
    wr_reg(ttc_pkg::CTRL2_ADDR, 8'h04);
    wait_pulse(2, 60);
    rd_chk("ovf_flag", ttc_pkg::CTRL2_ADDR, 8'h84);
    wr_reg(ttc_pkg::CTRL2_ADDR, 8'h00);
    rd_chk("ovf_low", ttc_pkg::CNT2L_ADDR, 8'hF0);
    rd_chk("ovf_high", ttc_pkg::CNT2H_ADDR, 8'hFF);
    // baud generation
    wr_reg(ttc_pkg::RCL_ADDR, 8'hFE);
    wr_reg(ttc_pkg::CNT2L_ADDR, 8'hFE);
    wr_reg(ttc_pkg::CTRL2_ADDR, 8'h14);
    period(3, 16'd4, "baud_period");
    rd_chk("baud_noflag", ttc_pkg::CTRL2_ADDR, 8'h14);
    wr_reg(ttc_pkg::CTRL2_ADDR, 8'h1C);
    fall(3);
    rd_chk("baud_trig", ttc_pkg::CTRL2_ADDR, 8'h5C);
    chk("baud_irq", 16'd1, {15'h0000, t2_irq});
    conclude();
  end
endmodule // tb
